// ### testbench/bram36_fifo_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module bram36_fifo_checker (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [1:0] half_used,
    input wire logic fifo_mode,
    input wire logic fifo_decoupled,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic rd_valid,
    input wire logic single_err,
    input wire logic double_err,
    input wire logic [1:0] half_power_on,
    input wire logic fifo_full,
    input wire logic fifo_empty,
    input wire logic fifo_almost_empty,
    input wire logic ext_single,
    input wire logic ext_double
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // fifo requests, taken or refused by the controller
    sequence pop_ok; fifo_mode && rd_en && !fifo_empty; endsequence
    sequence pop_bad; fifo_mode && rd_en && fifo_empty; endsequence
    // a read one cycle back may still be clearing full
    sequence push_bad;
        fifo_mode && wr_en && fifo_full && !rd_en && !$past(rd_en) && !fifo_decoupled;
    endsequence
    // a write one cycle back may still be clearing empty
    sequence pop_quiet; !wr_en && !$past(wr_en) && !fifo_decoupled; endsequence
    sequence first_push; fifo_mode && !fifo_decoupled && fifo_empty && wr_en && !rd_en; endsequence
    pop_answer_a: assert property (pop_ok |-> ##2 rd_valid)
        else $error("fifo read not answered");
    pop_drop_a: assert property (pop_bad |-> ##2 !rd_valid)
        else $error("read while empty answered");
    empty_hold_a: assert property (pop_bad ##0 pop_quiet |=> fifo_empty)
        else $error("empty lost on refused read");
    full_hold_a: assert property (push_bad |=> fifo_full)
        else $error("full lost on refused write");
    empty_leave_a: assert property (first_push |-> ##[1:3] !fifo_empty)
        else $error("empty stuck after write");
    flag_excl_a: assert property (!(fifo_full && fifo_empty))
        else $error("full and empty together");
    empty_almost_a: assert property (fifo_mode && fifo_empty |-> fifo_almost_empty)
        else $error("empty without almost empty");
    gate_follow_a: assert property ($past(rst_n) |-> half_power_on == $past(half_used))
        else $error("half power gate mismatch");
    err_valid_a: assert property (single_err || double_err |-> rd_valid && !(single_err && double_err))
        else $error("error flag misplaced");
    ext_excl_a: assert property (!(ext_single && ext_double))
        else $error("codec flags both set");
    valid_cause_a: assert property (rd_valid |-> $past(rd_en, 2))
        else $error("answer without request");
endmodule
bind bram36_fifo bram36_fifo_checker u_checker (.core_clk(core_clk), .rst_n(rst_n),
    .half_used(half_used), .fifo_mode(fifo_mode), .fifo_decoupled(fifo_decoupled),
    .wr_en(wr_en), .rd_en(rd_en), .rd_valid(rd_valid), .single_err(single_err),
    .double_err(double_err), .half_power_on(half_power_on), .fifo_full(fifo_full),
    .fifo_empty(fifo_empty), .fifo_almost_empty(fifo_almost_empty),
    .ext_single(ext_single), .ext_double(ext_double));
`default_nettype wire

// ### testbench/dual_port_ram_ecc_fifo_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_ecc_fifo_bench import bram_pkg::*;;
    logic core_clk, rst_n, split_mode, ecc_en, fifo_mode, wr_en, rd_en, rd_valid;
    logic fifo_decoupled;
    logic single_err, double_err, fifo_full, fifo_almost_full, fifo_empty, fifo_almost_empty;
    logic ext_single, ext_double;
    logic [1:0] half_used, half_power_on;
    logic [9:0] af_lvl, ae_lvl;
    logic [15:0] wr_addr, rd_addr;
    logic [71:0] wr_data, rd_data, ext_dec_code;
    logic [63:0] ext_enc_data, ext_dec_data;
    logic [7:0] ext_enc_chk;
    width_t wr_width, rd_width;
    integer seed = 32'h72AC;
    int n_fail, compares, cyc;
    logic [71:0] exp_q[$], msk_q[$], fq[$];
    bram36_fifo u_bram36_fifo (.core_clk(core_clk), .rst_n(rst_n), .split_mode(split_mode),
        .half_used(half_used), .ecc_en(ecc_en), .cascade_en(1'b0), .cascade_upper(1'b0),
        .fifo_mode(fifo_mode), .fifo_decoupled(fifo_decoupled), .almost_full_level(af_lvl),
        .almost_empty_level(ae_lvl), .wr_width(wr_width), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .rd_width(rd_width), .rd_en(rd_en), .rd_addr(rd_addr),
        .rd_data(rd_data), .rd_valid(rd_valid), .single_err(single_err),
        .double_err(double_err), .half_power_on(half_power_on), .fifo_full(fifo_full),
        .fifo_almost_full(fifo_almost_full), .fifo_empty(fifo_empty),
        .fifo_almost_empty(fifo_almost_empty), .ext_enc_data(ext_enc_data),
        .ext_enc_chk(ext_enc_chk), .ext_dec_code(ext_dec_code), .ext_dec_data(ext_dec_data),
        .ext_single(ext_single), .ext_double(ext_double));
    user_port_model u_user_port_model (.core_clk(core_clk), .fifo_full(fifo_full),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_en(rd_en), .rd_addr(rd_addr));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task check(input string nm, input logic [71:0] e, input logic [71:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task results();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // note the answer before asking, monitor pops it later
    task rd(input logic [15:0] a, input logic [71:0] e, input logic [71:0] m);
        exp_q.push_back(e & m);
        msk_q.push_back(m);
        u_user_port_model.get(a);
    endtask
    task idle(input int n);
        u_user_port_model.rest();
        repeat (n) @(posedge core_clk);
    endtask
    // monitor: sampled at the falling edge, well clear of updates
    always @(negedge core_clk) begin
        if (rd_valid === 1'b1) begin
            if (exp_q.size() == 0)
                check("unrequested rd_valid", 72'h0, 72'h1);
            else
                check("rd_data", exp_q.pop_front(), rd_data & msk_q.pop_front());
            check("err flags", 72'({single_err, double_err}), 72'h0);
        end
    end
    // hang guard; the run needs about 1650 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_fail++;
            $display("ERROR timeout expected done seen hang");
            results();
        end
    end
    initial begin
        int wid[7] = '{1, 2, 4, 9, 18, 36, 64};
        logic [95:0] r;
        logic [71:0] d;
        rst_n = 1'b0; split_mode = 1'b0; ecc_en = 1'b1; fifo_mode = 1'b0;
        fifo_decoupled = 1'b0;
        half_used = 2'b11; wr_width = W72; rd_width = W72;
        af_lvl = 10'h1F4; ae_lvl = 10'h003;
        ext_enc_data = 64'h0; ext_dec_code = 72'h0;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        // every width code, write then read back at once
        for (int k = 0; k < 7; k++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            d = r[71:0];
            wr_width <= width_t'(k);
            rd_width <= width_t'(k);
            u_user_port_model.put(16'h0005, d);
            rd(16'h0005, d, (72'h1 << wid[k]) - 72'h1);
            idle(3);
        end
        $display("test shapes done");
        split_mode <= 1'b1; half_used <= 2'b01; wr_width <= W36; rd_width <= W36;
        idle(2);
        check("half_power_on", 72'(half_power_on), 72'h1);
        u_user_port_model.put(16'h0258, d);
        u_user_port_model.get(16'h0258);
        u_user_port_model.put(16'h0004, ~d);
        rd(16'h0004, ~d, 72'hF_FFFF_FFFF);
        idle(4);
        $display("test halves done");
        r = {$random(seed), $random(seed), $random(seed)};
        ext_enc_data <= r[63:0];
        idle(2);
        ext_dec_code <= {ext_enc_chk, r[63:0] ^ 64'h80};
        idle(2);
        check("ext_dec_data", 72'(ext_dec_data), 72'(r[63:0]));
        check("ext_single", 72'(ext_single), 72'h1);
        ext_dec_code <= ext_dec_code ^ 72'h1;
        idle(2);
        check("ext_double", 72'(ext_double), 72'h1);
        $display("test codec done");
        // protection off so all 72 bits of each word come back
        split_mode <= 1'b0; half_used <= 2'b11; fifo_mode <= 1'b1; ecc_en <= 1'b0;
        idle(3);
        u_user_port_model.get(16'h0);
        for (int i = 0; i < 512; i++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            fq.push_back(r[71:0]);
            u_user_port_model.put(16'h0, r[71:0]);
            if (i == 2 || i == 3 || i == 498) begin
                idle(3);
                check("almost_empty", 72'(fifo_almost_empty), 72'(i == 2));
                check("almost_full", 72'(fifo_almost_full), 72'h0);
            end
        end
        idle(3);
        check("full", 72'({fifo_full, fifo_almost_full}), 72'h3);
        u_user_port_model.misuse = 1;
        u_user_port_model.put(16'h0, ~d);
        idle(3);
        u_user_port_model.misuse = 0;
        check("full after refused write", 72'(fifo_full), 72'h1);
        u_user_port_model.gap = 1;
        for (int i = 0; i < 512; i++)
            rd(16'h0, fq.pop_front(), 72'hFF_FFFF_FFFF_FFFF_FFFF);
        u_user_port_model.gap = 0;
        idle(4);
        check("empty", 72'({fifo_empty, fifo_almost_empty}), 72'h3);
        u_user_port_model.get(16'h0);
        idle(4);
        $display("test fifo done");
        // decoupled view, protection on: only the 64 data bits are compared
        fifo_decoupled <= 1'b1; ecc_en <= 1'b1;
        idle(3);
        for (int i = 0; i < 3; i++) begin
            r = {$random(seed), $random(seed), $random(seed)};
            fq.push_back(r[71:0]);
            u_user_port_model.put(16'h0, r[71:0]);
        end
        idle(6);
        check("decoupled empty", 72'({fifo_empty, fifo_almost_empty}), 72'h1);
        for (int i = 0; i < 3; i++)
            rd(16'h0, fq.pop_front(), 72'h0_FFFF_FFFF_FFFF_FFFF);
        idle(4);
        check("decoupled drained", 72'(fifo_empty), 72'h1);
        $display("test decoupled done");
        results();
    end
endmodule
`default_nettype wire

// ### testbench/user_port_model.sv
`timescale 1ns/1ps
`default_nettype none
module user_port_model (
    input wire logic core_clk,
    input wire logic fifo_full,
    output logic wr_en,
    output logic [15:0] wr_addr,
    output logic [71:0] wr_data,
    output logic rd_en,
    output logic [15:0] rd_addr
);
    bit misuse;
    int gap;
    // quiet ports; misuse only when the bench asks for it
    initial begin
        wr_en = 1'b0; rd_en = 1'b0; wr_addr = 16'h0; rd_addr = 16'h0;
        wr_data = 72'h0; misuse = 0; gap = 0;
    end
    task put(input logic [15:0] a, input logic [71:0] d);
        rd_en <= 1'b0;
        wr_en <= misuse || fifo_full !== 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge core_clk);
        // slow writer: stalls between words
        if (gap > 0) begin
            wr_en <= 1'b0;
            repeat (gap) @(posedge core_clk);
        end
    endtask
    task get(input logic [15:0] a);
        wr_en <= 1'b0;
        wr_data <= ~wr_data;
        rd_en <= 1'b1;
        rd_addr <= a;
        @(posedge core_clk);
        if (gap > 0) begin
            rd_en <= 1'b0;
            repeat (gap) @(posedge core_clk);
        end
    endtask
    // released lines toggle so stale data never looks valid
    task rest();
        wr_en <= 1'b0;
        rd_en <= 1'b0;
        wr_data <= ~wr_data;
        rd_addr <= ~rd_addr;
    endtask
endmodule
`default_nettype wire

// ### verilog/bram36_fifo.sv
// Contract
// - block works as one 36 Kb memory or two independent 18 Kb halves
// - 36 Kb shapes from 32Kx1 through 512x72
// - 64Kx1 only by cascading with the adjacent block
// - 18 Kb half shapes from 16Kx1 through 512x36
// - an unused 18 Kb half is power gated
// - 64-bit words get eight check bits, single fix, double flag
// - codec usable alone for external 64 to 72 bit memories
// - fifo runs on one shared clock or decoupled write/read sides
// - fifo steps its own addresses, drives full, empty, almost flags
`timescale 1ns/1ps
`default_nettype none
`include "bram_map.svh"
module bram36_fifo import bram_pkg::*; (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic split_mode,
    input wire logic [1:0] half_used,
    input wire logic ecc_en,
    input wire logic cascade_en,
    input wire logic cascade_upper,
    input wire logic fifo_mode,
    input wire logic fifo_decoupled,
    input wire logic [9:0] almost_full_level,
    input wire logic [9:0] almost_empty_level,
    input wire width_t wr_width,
    input wire logic wr_en,
    input wire logic [15:0] wr_addr,
    input wire logic [71:0] wr_data,
    input wire width_t rd_width,
    input wire logic rd_en,
    input wire logic [15:0] rd_addr,
    output logic [71:0] rd_data,
    output logic rd_valid,
    output logic single_err,
    output logic double_err,
    output logic [1:0] half_power_on,
    output logic fifo_full,
    output logic fifo_almost_full,
    output logic fifo_empty,
    output logic fifo_almost_empty,
    input wire logic [63:0] ext_enc_data,
    output logic [7:0] ext_enc_chk,
    input wire logic [71:0] ext_dec_code,
    output logic [63:0] ext_dec_data,
    output logic ext_single,
    output logic ext_double
);
    logic [71:0] mem [`ROWS];

    // bits per element for each width code
    function automatic logic [6:0] elem_bits(input width_t w);
        unique case (w)
            W1: elem_bits = 7'h01;
            W2: elem_bits = 7'h02;
            W4: elem_bits = 7'h04;
            W9: elem_bits = 7'h09;
            W18: elem_bits = 7'h12;
            W36: elem_bits = 7'h24;
            W72: elem_bits = 7'h48;
            // code 3'h7 is unused; treat it as the widest shape
            default: elem_bits = 7'h48;
        endcase
    endfunction

    // row and bit offset of an element; rows hold 64 or 72 bits
    function automatic logic [15:0] locate(input width_t w, input logic [15:0] a);
        logic [2:0] sh;
        logic [14:0] row;
        logic [14:0] lane;
        sh = 3'h6 - 3'(w);
        row = a[14:0] >> sh;
        lane = a[14:0] & ((15'h0001 << sh) - 15'h0001);
        locate = {row[8:0], 7'(lane[5:0] * elem_bits(w))};
    endfunction

    // decides whether an access belongs to this block and a live half
    function automatic logic owns(input width_t w, input logic [15:0] a,
                                  input logic [8:0] row);
        logic ok;
        ok = half_used[row[`HALF_ROW_BIT]];
        if (cascade_en) ok = ok && w == W1 && a[`CASC_BIT] == cascade_upper;
        else ok = ok && !a[`CASC_BIT];
        if (split_mode && w == W72) ok = 1'b0;
        owns = ok;
    endfunction

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            half_power_on <= 2'h0;
        end else begin
            half_power_on <= half_used;
        end
    end

    // encoder and decoder for stored words
    logic [7:0] chk;
    logic [71:0] rd_row;
    logic [63:0] fixed;
    logic fix_single;
    logic fix_double;
    secded_codec u_mem_codec (
        .enc_data(wr_data[63:0]),
        .enc_chk(chk),
        .dec_code(rd_row),
        .dec_data(fixed),
        .dec_single(fix_single),
        .dec_double(fix_double)
    );

    logic [7:0] x_chk;
    logic [63:0] x_data;
    logic x_single;
    logic x_double;
    secded_codec u_ext_codec (
        .enc_data(ext_enc_data),
        .enc_chk(x_chk),
        .dec_code(ext_dec_code),
        .dec_data(x_data),
        .dec_single(x_single),
        .dec_double(x_double)
    );
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_enc_chk <= 8'h00;
            ext_dec_data <= 64'h0;
            ext_single <= 1'b0;
            ext_double <= 1'b0;
        end else begin
            ext_enc_chk <= x_chk;
            ext_dec_data <= x_data;
            ext_single <= x_single;
            ext_double <= x_double;
        end
    end

    // fifo pointers: binary, gray copies, and the view of the far side
    logic [9:0] wptr;
    logic [9:0] rptr;
    logic [9:0] wgray;
    logic [9:0] rgray;
    logic [9:0] wgray_s1;
    logic [9:0] wgray_s2;
    logic [9:0] rgray_s1;
    logic [9:0] rgray_s2;
    logic [71:0] fifo_wdata;
    logic fifo_wr;
    logic fifo_rd;
    logic [9:0] next_wptr;
    logic [9:0] next_rptr;
    logic [9:0] wptr_view;
    logic [9:0] rptr_view;
    logic [9:0] wr_level;
    logic [9:0] rd_level;

    function automatic logic [9:0] gray2bin(input logic [9:0] g);
        gray2bin[9] = g[9];
        for (int i = 8; i >= 0; i--) begin
            gray2bin[i] = gray2bin[i + 1] ^ g[i];
        end
    endfunction

    assign fifo_wdata = wr_data;
    assign fifo_wr = fifo_mode && wr_en && !fifo_full;
    assign fifo_rd = fifo_mode && rd_en && !fifo_empty;
    assign next_wptr = fifo_wr ? wptr + 10'h001 : wptr;
    assign next_rptr = fifo_rd ? rptr + 10'h001 : rptr;
    // shared clock sees pointers directly, decoupled sees synced gray
    assign wptr_view = fifo_decoupled ? gray2bin(wgray_s2) : wptr;
    assign rptr_view = fifo_decoupled ? gray2bin(rgray_s2) : rptr;
    assign wr_level = next_wptr - rptr_view;
    assign rd_level = wptr_view - next_rptr;

    // write-side pointer and its gray copy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wptr <= 10'h000;
            wgray <= 10'h000;
        end else if (!fifo_mode) begin
            wptr <= 10'h000;
            wgray <= 10'h000;
        end else begin
            wptr <= next_wptr;
            wgray <= next_wptr ^ (next_wptr >> 1);
        end
    end

    // read-side pointer and its gray copy
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rptr <= 10'h000;
            rgray <= 10'h000;
        end else if (!fifo_mode) begin
            rptr <= 10'h000;
            rgray <= 10'h000;
        end else begin
            rptr <= next_rptr;
            rgray <= next_rptr ^ (next_rptr >> 1);
        end
    end

    // gray pointers cross through two stages each way
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            wgray_s1 <= 10'h000;
            wgray_s2 <= 10'h000;
            rgray_s1 <= 10'h000;
            rgray_s2 <= 10'h000;
        end else begin
            wgray_s1 <= wgray;
            wgray_s2 <= wgray_s1;
            rgray_s1 <= rgray;
            rgray_s2 <= rgray_s1;
        end
    end

    // full side from write pointer, empty side from read pointer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            fifo_full <= 1'b0;
            fifo_almost_full <= 1'b0;
            fifo_empty <= 1'b1;
            fifo_almost_empty <= 1'b1;
        end else begin
            // stale far pointers only make flags pessimistic, never unsafe
            fifo_full <= fifo_mode && wr_level == `FIFO_DEPTH;
            fifo_almost_full <= fifo_mode && wr_level >= almost_full_level;
            fifo_empty <= !fifo_mode || rd_level == 10'h000;
            fifo_almost_empty <= !fifo_mode || rd_level <= almost_empty_level;
        end
    end

    // write path: ram mode masks one element into its row
    logic [15:0] wloc;
    logic wr_fire;
    logic [8:0] wr_row;
    logic [71:0] wr_mask;
    logic [71:0] wr_val;
    always_comb begin
        wloc = locate(wr_width, wr_addr);
        wr_fire = 1'b0;
        wr_row = wloc[15:7];
        wr_mask = 72'h0;
        wr_val = 72'h0;
        if (fifo_mode) begin
            wr_fire = fifo_wr;
            wr_row = wptr[8:0];
            wr_mask = {72{1'b1}};
            wr_val = ecc_en ? {chk, fifo_wdata[63:0]} : fifo_wdata;
        end else if (wr_en && owns(wr_width, wr_addr, wloc[15:7])) begin
            wr_fire = 1'b1;
            wr_mask = ((72'h1 << elem_bits(wr_width)) - 72'h1) << wloc[6:0];
            wr_val = wr_data << wloc[6:0];
            // check bits stored beside full words
            if (ecc_en && wr_width == W72) wr_val = {chk, wr_data[63:0]};
        end
    end

    // one array, halves split by the row msb
    always_ff @(posedge core_clk) begin
        if (wr_fire) begin
            mem[wr_row] <= (mem[wr_row] & ~wr_mask) | (wr_val & wr_mask);
        end
    end

    // read stage one: fetch the row
    logic [15:0] rloc;
    logic rd_fire;
    logic rd_p1;
    logic [6:0] rd_off;
    width_t rd_w_q;
    logic rd_ecc_q;
    assign rloc = locate(rd_width, rd_addr);
    assign rd_fire = fifo_mode ? fifo_rd : rd_en && owns(rd_width, rd_addr, rloc[15:7]);
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_p1 <= 1'b0;
            rd_off <= 7'h00;
            rd_w_q <= W1;
            rd_ecc_q <= 1'b0;
            rd_row <= 72'h0;
        end else begin
            rd_p1 <= rd_fire;
            if (rd_fire) begin
                rd_row <= mem[fifo_mode ? rptr[8:0] : rloc[15:7]];
                rd_off <= fifo_mode ? 7'h00 : rloc[6:0];
                rd_w_q <= fifo_mode ? W72 : rd_width;
                rd_ecc_q <= ecc_en && (fifo_mode || rd_width == W72);
            end
        end
    end

    // read stage two: extract element or corrected word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 72'h0;
            rd_valid <= 1'b0;
            single_err <= 1'b0;
            double_err <= 1'b0;
        end else begin
            rd_valid <= rd_p1;
            single_err <= rd_p1 && rd_ecc_q && fix_single;
            double_err <= rd_p1 && rd_ecc_q && fix_double;
            if (rd_p1) begin
                if (rd_ecc_q) rd_data <= {rd_row[71:64], fixed};
                else rd_data <= (rd_row >> rd_off) & ((72'h1 << elem_bits(rd_w_q)) - 72'h1);
            end
        end
    end
endmodule
`default_nettype wire

// ### verilog/bram_map.svh
`ifndef BRAM_MAP_SVH
`define BRAM_MAP_SVH
// storage shape: 512 rows of 72 bits, 36 Kb total
`define ROWS 512
`define ROW_W 72
`define ROW_AW 9
`define HALF_ROW_BIT 8
// element address: 15 bits inside one block plus the cascade bit
`define ADDR_W 16
`define CASC_BIT 15
// fifo pointers carry one wrap bit above the row address
`define PTR_W 10
`define FIFO_DEPTH 10'h200
// check bits sit above the 64 data bits of a row
`define ECC_DATA_W 64
`define ECC_CHK_W 8
`define ECC_CHK_LSB 64
`endif

// ### verilog/bram_pkg.sv
package bram_pkg;
    // port width codes: 32Kx1 up to 512x72
    typedef enum logic [2:0] {W1, W2, W4, W9, W18, W36, W72} width_t;
endpackage

// ### verilog/secded_codec.sv
`timescale 1ns/1ps
`default_nettype none
`include "bram_map.svh"
// hamming (72,64): check bits {overall, p64..p1} in enc_chk
module secded_codec (
    input wire logic [63:0] enc_data,
    output logic [7:0] enc_chk,
    input wire logic [71:0] dec_code,
    output logic [63:0] dec_data,
    output logic dec_single,
    output logic dec_double
);
    // encoder: data fills the non power-of-two positions 1..71
    always_comb begin
        int di;
        logic [6:0] p;
        di = 0;
        p = 7'h00;
        for (int pos = 1; pos < 72; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                for (int k = 0; k < 7; k++) begin
                    if (pos[k]) p[k] = p[k] ^ enc_data[di];
                end
                di++;
            end
        end
        enc_chk = {(^enc_data) ^ (^p), p};
    end

    // decoder: syndrome points at the flipped position
    always_comb begin
        int di;
        logic [6:0] syn;
        logic all_par;
        di = 0;
        syn = dec_code[70:64];
        all_par = ^dec_code;
        dec_data = dec_code[63:0];
        for (int pos = 1; pos < 72; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                for (int k = 0; k < 7; k++) begin
                    if (pos[k]) syn[k] = syn[k] ^ dec_code[di];
                end
                di++;
            end
        end
        di = 0;
        for (int pos = 1; pos < 72; pos++) begin
            if ((pos & (pos - 1)) != 0) begin
                // flip only on an odd overall parity: single error
                if (all_par && syn == 7'(pos)) dec_data[di] = ~dec_code[di];
                di++;
            end
        end
        dec_single = all_par;
        // even overall parity with a syndrome means two bits went bad
        dec_double = !all_par && syn != 7'h00;
    end
endmodule
`default_nettype wire
